// ===== include/boot_cfg1_cfg.svh
// Constants of the boot configuration word decoder: offsets, field positions, reset values, counts.
// Assumes inclusion by bare name from the package and the testbench.
`ifndef BOOT_CFG1_CFG_SVH
`define BOOT_CFG1_CFG_SVH

// ==========================================================================
// Register byte offsets
`define CFG_OFS_WORD_ONE 4'h0
`define CFG_OFS_PART_ID 4'h4
`define CFG_OFS_SERIAL_LO 4'h8
`define CFG_OFS_SERIAL_HI 4'hc
`define CFG_OFS_STATUS 4'h0

// ==========================================================================
// Field positions
`define CFG_WDT_MSB 20
`define CFG_WDT_LSB 16
`define CFG_FAIL_MON_BIT 15
`define CFG_CLK_SW_BIT 14
`define CFG_RSVD_MSB 13
`define CFG_RSVD_LSB 11
`define CFG_CLKOUT_DIS_BIT 10
`define CFG_POSC_MSB 9
`define CFG_POSC_LSB 8
`define CFG_TWO_SPEED_BIT 7
`define CFG_SOSC_BIT 6
`define CFG_DMT_MSB 5
`define CFG_DMT_LSB 3

// ==========================================================================
// Values
`define CFG_WDT_MAX_CODE 5'h14
`define CFG_WORD_RESET 32'hffffffff
`define CFG_DATA_RESET 32'h00000000
`define CFG_PART_ID_DEFAULT 32'h0a5a0001
`define CFG_LOAD_WAIT_CYCLES 4'h2

`endif

// ===== include/boot_cfg1_pkg.sv
// Types of the boot configuration word decoder.
// Assumes the constants header is on the include path.
`include "boot_cfg1_cfg.svh"

package boot_cfg1_pkg;

  typedef enum logic [1:0] {
    posc_disabled_mode,
    high_speed_crystal_mode,
    posc_reserved_mode,
    external_clock_input_mode
  } posc_mode_type;

  typedef enum logic [1:0] {
    st_wait,
    st_load,
    st_hold
  } load_state_type;

  typedef struct packed {
    logic [4:0] watchdog_postscale_sel;
    logic [20:0] watchdog_ratio_log2;
    logic clk_fail_monitor_en;
    logic clk_switch_en;
    logic clk_out_disable;
    logic clock_output_en;
    posc_mode_type primary_osc_mode;
    logic two_speed_startup_en;
    logic secondary_osc_en;
    logic [2:0] deadman_window_sel;
    logic [7:0] deadman_window_num;
    logic [7:0] deadman_window_den;
  } settings_type;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avalon_req_type;

endpackage

// ===== rtl/boot_config_word1_decode.sv
// Decoder of the second boot configuration word into static settings, plus read-only id registers.
// Assumes config words arrive synchronous to clk_in from the boot flash reader.
`timescale 1ns/1ps
`default_nettype none

module boot_config_word1_decode
  import boot_cfg1_pkg::*;
#(
  parameter logic [31:0] part_revision_id_value = `CFG_PART_ID_DEFAULT // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic [31:0] alias_word_one_in,
  input wire logic [31:0] boot1_word_one_in,
  input wire logic [31:0] boot2_word_one_in,
  input wire logic lower_alias_sel_boot2_in,
  input wire logic [31:0] serial_number_low_in,
  input wire logic [31:0] serial_number_high_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic cfg_valid_out,
  output settings_type settings_out
);

  typedef struct packed {
    load_state_type state;
    logic [3:0] wait_count;
    logic [31:0] word_one;
    logic [31:0] serial_lo;
    logic [31:0] serial_hi;
    settings_type settings;
    logic valid;
    logic [31:0] readdata;
    logic waitrequest;
  } state_type;

  state_type current;
  state_type next_current;
  avalon_req_type req;
  logic [31:0] chosen_word;
  settings_type decoded;

  // ==========================================================================
  // Source selection and field decode
  assign req = '{address: avs_address_in, read: avs_read_in, write: avs_write_in, writedata: avs_writedata_in};

  always_comb begin
    logic [4:0] wdt_code;
    logic [2:0] dmt_code;
    wdt_code = '0;
    dmt_code = '0;
    chosen_word = alias_word_one_in;
    if (lower_alias_sel_boot2_in) begin
      chosen_word = boot2_word_one_in;
    end else begin
      chosen_word = boot1_word_one_in;
    end
    wdt_code = chosen_word[`CFG_WDT_MSB:`CFG_WDT_LSB];
    if (wdt_code > `CFG_WDT_MAX_CODE) begin
      wdt_code = `CFG_WDT_MAX_CODE;
    end
    decoded = '0;
    decoded.watchdog_postscale_sel = wdt_code;
    decoded.watchdog_ratio_log2 = 21'h000001 << wdt_code;
    decoded.clk_fail_monitor_en = chosen_word[`CFG_FAIL_MON_BIT];
    decoded.clk_switch_en = chosen_word[`CFG_CLK_SW_BIT];
    decoded.clk_out_disable = chosen_word[`CFG_CLKOUT_DIS_BIT];
    unique case (chosen_word[`CFG_POSC_MSB:`CFG_POSC_LSB])
      2'h3: decoded.primary_osc_mode = posc_disabled_mode;
      2'h2: decoded.primary_osc_mode = high_speed_crystal_mode;
      2'h1: decoded.primary_osc_mode = posc_reserved_mode;
      2'h0: decoded.primary_osc_mode = external_clock_input_mode;
    endcase
    decoded.clock_output_en = !chosen_word[`CFG_CLKOUT_DIS_BIT] &&
      (decoded.primary_osc_mode == posc_disabled_mode ||
       decoded.primary_osc_mode == external_clock_input_mode);
    decoded.two_speed_startup_en = chosen_word[`CFG_TWO_SPEED_BIT];
    decoded.secondary_osc_en = chosen_word[`CFG_SOSC_BIT];
    dmt_code = chosen_word[`CFG_DMT_MSB:`CFG_DMT_LSB];
    decoded.deadman_window_sel = dmt_code;
    decoded.deadman_window_den = 8'h01 << dmt_code;
    decoded.deadman_window_num = (dmt_code == 3'h0) ? 8'h00 : ((8'h01 << dmt_code) - 8'h01);
  end

  // ==========================================================================
  // Load sequence and register bus
  always_comb begin
    next_current = current;
    next_current.waitrequest = 1'b1;
    unique case (current.state)
      st_wait: begin
        next_current.wait_count = current.wait_count + 4'h1;
        if (current.wait_count == `CFG_LOAD_WAIT_CYCLES) begin
          next_current.state = st_load;
        end
      end
      st_load: begin
        next_current.word_one = chosen_word;
        next_current.settings = decoded;
        next_current.serial_lo = serial_number_low_in;
        next_current.serial_hi = serial_number_high_in;
        next_current.valid = 1'b1;
        next_current.state = st_hold;
      end
      st_hold: begin
        // Answer each access one cycle after it is presented; writes are ignored
        if ((req.read || req.write) && current.waitrequest) begin
          next_current.waitrequest = 1'b0;
          next_current.readdata = '0;
          if (req.read) begin
            unique case (req.address)
              `CFG_OFS_WORD_ONE: next_current.readdata = current.word_one;
              `CFG_OFS_PART_ID: next_current.readdata = part_revision_id_value;
              `CFG_OFS_SERIAL_LO: next_current.readdata = current.serial_lo;
              `CFG_OFS_SERIAL_HI: next_current.readdata = current.serial_hi;
              default: next_current.readdata = '0;
            endcase
          end
        end
      end
      default: next_current.state = st_wait;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      current <= '0;
      current.state <= st_wait;
      current.waitrequest <= 1'b1;
    end else if (clk_en_in) begin
      current <= next_current;
    end
  end

  assign avs_readdata_out = current.readdata;
  assign avs_waitrequest_out = current.waitrequest;
  assign cfg_valid_out = current.valid;
  assign settings_out = current.settings;

endmodule

`default_nettype wire

// ===== tb/boot_cfg1_sva.sv
// Port checker of the boot word decoder.
// Assumes it is bound to boot_config_word1_decode.
`timescale 1ns/1ps
`default_nettype none
module boot_cfg1_sva
  import boot_cfg1_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic avs_read_in,
  input wire logic avs_waitrequest_out,
  input wire logic cfg_valid_out,
  input wire settings_type settings_out
);
  wire settings_type s = settings_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ====
  // Checks
  a_ps_clamp: assert property (cfg_valid_out |-> s.watchdog_postscale_sel <= 5'h14) else $error("ps");
  a_ratio_pow: assert property (cfg_valid_out |->
    s.watchdog_ratio_log2 == 21'h1 << s.watchdog_postscale_sel) else $error("ratio");
  a_clkout_gate: assert property (cfg_valid_out |-> s.clock_output_en == (!s.clk_out_disable &&
    s.primary_osc_mode inside {posc_disabled_mode, external_clock_input_mode})) else $error("clkout");
  a_dmt_frac: assert property (cfg_valid_out && s.deadman_window_sel != 3'h0 |->
    s.deadman_window_den == 8'h1 << s.deadman_window_sel &&
    s.deadman_window_num == s.deadman_window_den - 8'h1) else $error("dmt");
  a_dmt_zero: assert property (cfg_valid_out && s.deadman_window_sel == 3'h0 |->
    s.deadman_window_num == 8'h0) else $error("dmt0");
  a_cfg_hold: assert property (cfg_valid_out |=> cfg_valid_out && $stable(s)) else $error("hold");
  a_ans_next: assert property ($rose(avs_read_in) && cfg_valid_out && avs_waitrequest_out |=>
    !avs_waitrequest_out) else $error("ack");
  a_ans_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("ack1");
  a_no_early: assert property (!cfg_valid_out |-> avs_waitrequest_out) else $error("early");
endmodule
bind boot_config_word1_decode boot_cfg1_sva i_boot_cfg1_sva (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .avs_read_in(avs_read_in), .avs_waitrequest_out(avs_waitrequest_out), .cfg_valid_out(cfg_valid_out),
  .settings_out(settings_out));
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the boot word decoder.
// Assumes the package and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "boot_cfg1_cfg.svh"
module testbench
  import boot_cfg1_pkg::*;
;
  typedef struct packed {logic [31:0] w; logic [4:0] ps; posc_mode_type m; logic ck;} row_type;
  row_type rows [5] = '{'{32'hffffffff, 5'h14, posc_disabled_mode, 1'b0},
    '{32'hffe0b88f, 5'h00, external_clock_input_mode, 1'b1},
    '{32'hfff37a7f, 5'h13, high_speed_crystal_mode, 1'b0},
    '{32'hfff53907, 5'h14, posc_reserved_mode, 1'b0},
    '{32'hffe5fbc7, 5'h05, posc_disabled_mode, 1'b1}};
  logic clk_in = 1'b0, rst_b_in = 1'b0, rd = 1'b0, wr = 1'b0, sel = 1'b0, en = 1'b1, wreq, vld;
  logic [3:0] adr = 4'h0;
  logic [31:0] w1 = 32'h0, w2 = 32'h0, q, rdata;
  settings_type s;
  int err_total = 0, compares = 0, i;
  always #10 clk_in = ~clk_in;
  boot_config_word1_decode i_boot_config_word1_decode (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .clk_en_in(en), .alias_word_one_in(32'h0), .boot1_word_one_in(w1), .boot2_word_one_in(w2),
    .lower_alias_sel_boot2_in(sel), .serial_number_low_in(32'h12345678),
    .serial_number_high_in(32'h9abcdef0), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(32'h0), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .cfg_valid_out(vld), .settings_out(s));
  task stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task boot(input logic [31:0] w, input logic b);
    rst_b_in <= 1'b0;
    sel <= b;
    w1 <= b ? ~w : w;
    w2 <= b ? w : ~w;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask
  task bus(input logic [3:0] a, input logic w);
    int k;
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    k = 0;
    // Request stands until the edge at which waitrequest is sampled low
    do begin
      @(posedge clk_in);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    chk("ack", 32'h0, {31'h0, wreq});
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  initial begin
    for (i = 0; i < 5; i++) begin
      boot(rows[i].w, i[0]);
      chk("valid", 32'h1, {31'h0, vld});
      chk("ps", {27'h0, rows[i].ps}, {27'h0, s.watchdog_postscale_sel});
      chk("ratio", 32'h1 << rows[i].ps, {11'h0, s.watchdog_ratio_log2});
      chk("monsw", {30'h0, rows[i].w[15:14]}, {30'h0, s.clk_fail_monitor_en, s.clk_switch_en});
      chk("mode", {30'h0, rows[i].m}, {30'h0, s.primary_osc_mode});
      chk("clkout", {30'h0, rows[i].w[10], rows[i].ck}, {30'h0, s.clk_out_disable, s.clock_output_en});
      chk("tssosc", {30'h0, rows[i].w[7:6]}, {30'h0, s.two_speed_startup_en, s.secondary_osc_en});
      chk("dmt", {24'h0, (8'h1 << rows[i].w[5:3]) - 8'h1}, {24'h0, s.deadman_window_num});
      chk("dmtden", {24'h0, 8'h1 << rows[i].w[5:3]}, {24'h0, s.deadman_window_den});
      chk("dmtsel", {29'h0, rows[i].w[5:3]}, {29'h0, s.deadman_window_sel});
      bus(4'h0, 1'b0);
      chk("word", rows[i].w, q);
    end
    bus(4'h4, 1'b0);
    chk("id", `CFG_PART_ID_DEFAULT, q);
    bus(4'h8, 1'b0);
    chk("snlo", 32'h12345678, q);
    bus(4'hc, 1'b0);
    chk("snhi", 32'h9abcdef0, q);
    bus(4'h2, 1'b0);
    chk("unmapped", 32'h0, q);
    bus(4'h0, 1'b1);
    w1 <= 32'h0;
    sel <= 1'b1;
    bus(4'h0, 1'b0);
    chk("held", rows[4].w, q);
    rst_b_in <= 1'b0;
    @(posedge clk_in);
    en <= 1'b0;
    rst_b_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk("frozen", 32'h0, {31'h0, vld});
    en <= 1'b1;
    bus(4'h4, 1'b0);
    chk("idearly", `CFG_PART_ID_DEFAULT, q);
    stop_test();
  end
  initial begin
    repeat (4000) @(posedge clk_in);
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
